// *** logic/sdram_cmd_pkg.sv ***
// Constants and types for the DRAM command, refresh and power block
package sdram_cmd_pkg;

  // ----------------------------------------------------------------
  // Clock and refresh timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;       // 20 MHz device clock
  localparam int REFRESH_ROWS      = 4096;     // Rows per refresh window
  localparam int REFRESH_WINDOW_MS = 64;       // Commercial window
  localparam int ROW_INTERVAL_NS   =
    (REFRESH_WINDOW_MS * 1000000) / REFRESH_ROWS;
  // Longest spacing, so round down
  localparam int REFRESH_INTERVAL_CYC = ROW_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int ROW_CYCLE_NS      = 60;       // Minimum row cycle time
  // Least time, so round up
  localparam int ROW_CYCLE_CYC     =
    (ROW_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         ROW_W       = 12;
  localparam int         TIMER_W     = 9;
  localparam int         CNT_W       = 2;
  localparam logic [11:0] ROW_RESET  = 12'h000;
  localparam logic [8:0]  TIMER_RESET = 9'(REFRESH_INTERVAL_CYC - 1);
  localparam logic [1:0]  BUSY_LOAD  = 2'(ROW_CYCLE_CYC);

  // ----------------------------------------------------------------
  // Column latency field
  // ----------------------------------------------------------------
  localparam logic [2:0] CL2_CODE = 3'h2;
  localparam logic [2:0] CL3_CODE = 3'h3;
  localparam logic [1:0] CL2_CYC  = 2'h2;
  localparam logic [1:0] CL3_CYC  = 2'h3;

  // Decoded command on the sampled pins
  typedef enum logic [2:0] {
    CMD_DESELECT, CMD_NOP, CMD_BURST_STOP, CMD_REFRESH, CMD_OTHER
  } cmd_t;

  // Clock and power state
  typedef enum logic [1:0] {
    PWR_ACTIVE, PWR_SUSPEND, PWR_DOWN, PWR_SELF_REFRESH
  } pwr_t;

endpackage

// *** logic/sdram_refresh_power_cmds.sv ***
// Command decode, burst stop, refresh and power states of the DRAM
`timescale 1ns/1ps

// Contract
// - Selected all-high strobes is no-operation
// - Only write enable low is burst stop
// - Burst stop ignored for auto-precharge bursts
// - Stopped read drives data for latency clocks
// - Chip select high ignores all command inputs
// - Row and column low starts auto refresh
// - Refresh row counter advances by one
// - Refresh with clock enable falling: self refresh
// - Self refresh times and addresses itself
// - Enable low in burst freezes internal clock
// - Enable low while idle enters power-down
// - Enable high restarts clock and buffers
// - Data mask blocks writes and read outputs
// - Latency code 010 two, 011 three
module sdram_refresh_power_cmds
  import sdram_cmd_pkg::*;
#(
  parameter int DQM_W = 4
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_b,
  // Command pins from the controller
  input  wire logic             csB,
  input  wire logic             rasB,
  input  wire logic             casB,
  input  wire logic             weB,
  input  wire logic             cke,
  input  wire logic [DQM_W-1:0] dqm,
  // Core status
  input  wire logic             allBanksIdle,
  input  wire logic             burstActive,
  input  wire logic             burstRead,
  input  wire logic             burstAutoPre,
  input  wire logic             readWordValid,
  input  wire logic             writeWordValid,
  input  wire logic [2:0]       casLatCode,
  // Results to the core
  output logic                  burstHalt,
  output logic                  readEnd,
  output logic                  refreshPulse,
  output logic [ROW_W-1:0]      refreshRow,
  output logic                  refreshBusy,
  output logic                  internalClkEn,
  output logic                  buffersOn,
  output logic                  selfRefresh,
  output logic                  casLatReserved,
  output logic [DQM_W-1:0]      writeEn,
  output logic [DQM_W-1:0]      dqOutEn
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Decode the strobe pins; clock enable splits refresh kinds later
  function automatic cmd_t decodeCmd(input logic cs, input logic ras,
                                     input logic cas, input logic we);
    cmd_t c;
    c = CMD_OTHER;
    if (cs) begin
      c = CMD_DESELECT;
    end else if (ras && cas && we) begin
      c = CMD_NOP;
    end else if (ras && cas && !we) begin
      c = CMD_BURST_STOP;
    end else if (!ras && !cas && we) begin
      c = CMD_REFRESH;
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  logic             csB_q;      // Sampled chip select
  logic             rasB_q;     // Sampled row strobe
  logic             casB_q;     // Sampled column strobe
  logic             weB_q;      // Sampled write enable
  logic             cke_q;      // Clock enable this cycle
  logic             ckePrev_q;  // Clock enable one cycle earlier
  logic [DQM_W-1:0] dqm_q;      // Sampled data mask

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      csB_q     <= 1'b1;
      rasB_q    <= 1'b1;
      casB_q    <= 1'b1;
      weB_q     <= 1'b1;
      // Enable reads high out of reset, else a false power-down follows
      cke_q     <= 1'b1;
      ckePrev_q <= 1'b1;
      dqm_q     <= '1;
    end else begin
      csB_q     <= csB;
      rasB_q    <= rasB;
      casB_q    <= casB;
      weB_q     <= weB;
      cke_q     <= cke;
      ckePrev_q <= cke_q;
      dqm_q     <= dqm;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  cmd_t       cmd;      // Command on the sampled pins
  logic [1:0] latency;  // Column latency in clocks
  logic       cmdLive;  // Clock ran last cycle, command counts

  assign cmd = decodeCmd(csB_q, rasB_q, casB_q, weB_q);

  assign latency = (casLatCode == CL2_CODE) ? CL2_CYC : CL3_CYC;
  // Reserved codes fall back to three clocks, the safe choice
  assign casLatReserved = (casLatCode != CL2_CODE) &&
                          (casLatCode != CL3_CODE);

  // ----------------------------------------------------------------
  // Main state
  // ----------------------------------------------------------------
  pwr_t               state_q,      state_d;
  logic [ROW_W-1:0]   row_q,        row_d;        // Refresh row
  logic [TIMER_W-1:0] timer_q,      timer_d;      // Self refresh timer
  logic [CNT_W-1:0]   busy_q,       busy_d;       // Row cycle left
  logic [CNT_W-1:0]   drain_q,      drain_d;      // Read drain left
  logic               readCut_q,    readCut_d;    // Read output ended
  logic               halt_q,       halt_d;
  logic               readEnd_q,    readEnd_d;
  logic               refPulse_q,   refPulse_d;
  logic [DQM_W-1:0]   writeEn_q,    writeEn_d;
  logic [DQM_W-1:0]   dqOutEn_q,    dqOutEn_d;

  assign cmdLive = (state_q == PWR_ACTIVE) && ckePrev_q;

  // Next state of the whole command engine
  always_comb begin
    logic doRefresh;
    doRefresh  = 1'b0;
    state_d    = state_q;
    row_d      = row_q;
    timer_d    = timer_q;
    busy_d     = (busy_q != '0) ? busy_q - 2'h1 : busy_q;
    drain_d    = drain_q;
    readCut_d  = readCut_q && readWordValid;
    halt_d     = 1'b0;
    readEnd_d  = 1'b0;
    writeEn_d  = '0;
    dqOutEn_d  = '0;

    case (state_q)
      PWR_ACTIVE: begin
        // Commands count only when the clock ran last cycle
        if (ckePrev_q) begin
          if (cmd == CMD_BURST_STOP && burstActive && !burstAutoPre) begin
            halt_d = 1'b1;
            // read data runs out after latency
            if (burstRead) begin
              drain_d = latency;
            end
          end
          if (cmd == CMD_REFRESH) begin
            doRefresh = 1'b1;
          end
        end
        // Read drain counts only on running clocks
        if (drain_q != '0) begin
          drain_d = drain_q - 2'h1;
          if (drain_q == 2'h1) begin
            readCut_d = 1'b1;
            readEnd_d = 1'b1;
          end
        end
        if (ckePrev_q && !cke_q && cmd == CMD_REFRESH) begin
          state_d = PWR_SELF_REFRESH;
          timer_d = TIMER_RESET;
        end else if (!cke_q && burstActive) begin
          state_d = PWR_SUSPEND;
        end else if (!cke_q && allBanksIdle && busy_d == '0) begin
          state_d = PWR_DOWN;
        end else if (!cke_q) begin
          // Open rows or a refresh under way, no burst: clock masked, buffers kept
          state_d = PWR_SUSPEND;
        end
        // mask gates write and read words
        writeEn_d = writeWordValid ? ~dqm_q : '0;
        dqOutEn_d = (readWordValid && !readCut_d) ? ~dqm_q : '0;
      end
      PWR_SUSPEND: begin
        // Read drain and read output lanes held as they were; busy count runs on, write lanes off
        drain_d   = drain_q;
        readCut_d = readCut_q;
        dqOutEn_d = dqOutEn_q;
        if (cke_q) begin
          state_d = PWR_ACTIVE;
        end
      end
      PWR_DOWN: begin
        if (cke_q) begin
          state_d = PWR_ACTIVE;
        end
      end
      PWR_SELF_REFRESH: begin
        if (timer_q == '0) begin
          timer_d   = TIMER_RESET;
          doRefresh = 1'b1;
        end else begin
          timer_d = timer_q - 9'h001;
        end
        // Exit lets a refresh under way finish on the busy count
        if (cke_q) begin
          state_d = PWR_ACTIVE;
        end
      end
      default: begin
        state_d = PWR_ACTIVE;
      end
    endcase

    if (doRefresh) begin
      row_d  = row_q + 12'h001;
      busy_d = BUSY_LOAD;
    end
    refPulse_d = doRefresh;
  end

  // Register the engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= PWR_ACTIVE;
      row_q      <= ROW_RESET;
      timer_q    <= TIMER_RESET;
      busy_q     <= '0;
      drain_q    <= '0;
      readCut_q  <= 1'b0;
      halt_q     <= 1'b0;
      readEnd_q  <= 1'b0;
      refPulse_q <= 1'b0;
      writeEn_q  <= '0;
      dqOutEn_q  <= '0;
    end else begin
      state_q    <= state_d;
      row_q      <= row_d;
      timer_q    <= timer_d;
      busy_q     <= busy_d;
      drain_q    <= drain_d;
      readCut_q  <= readCut_d;
      halt_q     <= halt_d;
      readEnd_q  <= readEnd_d;
      refPulse_q <= refPulse_d;
      writeEn_q  <= writeEn_d;
      dqOutEn_q  <= dqOutEn_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign burstHalt     = halt_q;
  assign readEnd       = readEnd_q;
  assign refreshPulse  = refPulse_q;
  assign refreshRow    = row_q;
  assign refreshBusy   = (busy_q != '0);
  assign internalClkEn = (state_q == PWR_ACTIVE);
  assign buffersOn     = (state_q == PWR_ACTIVE) ||
                         (state_q == PWR_SUSPEND);
  assign selfRefresh   = (state_q == PWR_SELF_REFRESH);
  assign writeEn       = writeEn_q;
  assign dqOutEn       = dqOutEn_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  noop_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cmdLive && cmd == CMD_NOP) |=> !burstHalt && !refreshPulse)
    else $error("no-operation caused an action");

  stop_halt_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cmdLive && cmd == CMD_BURST_STOP && burstActive && !burstAutoPre)
    |=> burstHalt)
    else $error("burst stop not honoured");

  stop_autopre_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cmdLive && burstAutoPre) |=> !burstHalt)
    else $error("auto-precharge burst was stopped");

  read_drain_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cmdLive && cmd == CMD_BURST_STOP && burstActive && !burstAutoPre &&
     burstRead && casLatCode == CL2_CODE && cke_q)
    |=> (drain_q == CL2_CYC) ##1 (drain_q == 2'h1)
        ##1 (readEnd || !$past(internalClkEn)))
    else $error("read drain length wrong");

  deselect_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == PWR_ACTIVE && csB_q) |=> !burstHalt && !refreshPulse)
    else $error("deselect caused an action");

  refresh_row_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    refreshPulse |-> refreshRow == $past(refreshRow) + 12'h001
                     && refreshBusy)
    else $error("refresh row did not advance by one");

  self_entry_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cmdLive && !cke_q && cmd == CMD_REFRESH)
    |=> selfRefresh && !buffersOn)
    else $error("self refresh not entered");

  self_pace_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (selfRefresh && timer_q == '0) |=> refreshPulse)
    else $error("self refresh timer gave no refresh");

  suspend_mask_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == PWR_ACTIVE && !cke_q && burstActive &&
     !(ckePrev_q && cmd == CMD_REFRESH))
    |=> (!internalClkEn && buffersOn) ##1 $stable(drain_q))
    else $error("clock suspend not applied");

  wake_up_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ((state_q == PWR_SUSPEND || state_q == PWR_DOWN) && cke_q)
    |=> internalClkEn && buffersOn)
    else $error("clock enable high did not wake");

  mask_write_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (state_q == PWR_ACTIVE && writeWordValid && dqm_q[0])
    |=> !writeEn[0])
    else $error("masked write lane enabled");

endmodule

// *** dv/ctrl_model.sv ***
// Controller model that keeps the far-side command spacing
`timescale 1ns/1ps
module ctrl_model
  import sdram_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Requests from the bench: cs, ras, cas, we and clock enable
  input  wire logic [3:0] req,
  input  wire logic       reqCke,
  // Pins to the device
  output logic            csB,
  output logic            rasB,
  output logic            casB,
  output logic            weB,
  output logic            cke
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] hold_q;     // Idle cycles still owed to the device
  logic       ckePrev_q;  // Clock enable of the previous cycle
  logic       isRef;      // Request carries the refresh encoding
  assign isRef = (req == 4'h1);
  // Clock enable passes straight through; the bench drives it low only in the power tests
  assign cke   = reqCke;

  // Owed idle count, reloaded by a refresh or a clock-enable rise
  // idle after refresh
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hold_q    <= 2'h0;
      ckePrev_q <= 1'b0;
    end else begin
      ckePrev_q <= cke;
      if ((cke && !ckePrev_q) || ({csB, rasB, casB, weB} == 4'h1 && cke))
        hold_q <= BUSY_LOAD;
      else if (hold_q != 2'h0)
        hold_q <= hold_q - 2'h1;
    end
  end

  // Wake with deselect; refresh only with clock enable high before
  // gated refresh, exit
  always_comb begin
    if (reqCke && !ckePrev_q)
      {csB, rasB, casB, weB} = 4'hF;
    else if (hold_q != 2'h0 || (isRef && !ckePrev_q))
      {csB, rasB, casB, weB} = 4'h7;
    else
      {csB, rasB, casB, weB} = req;
  end
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the DRAM command, refresh and power block
`timescale 1ns/1ps
module tb;
  import sdram_cmd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic             clock          = 1'b0;     // 20 MHz
  logic             rst_b          = 1'b0;
  logic [3:0]       req            = 4'h7;     // Requested pins
  logic             reqCke         = 1'b1;
  logic [3:0]       dqm            = 4'h0;
  logic             allBanksIdle   = 1'b1;
  logic             burstActive    = 1'b0;
  logic             burstRead      = 1'b0;
  logic             burstAutoPre   = 1'b0;
  logic             readWordValid  = 1'b0;
  logic             writeWordValid = 1'b0;
  logic [2:0]       casLatCode     = CL2_CODE;
  logic             csB, rasB, casB, weB, cke;
  logic             burstHalt, readEnd, refreshPulse, refreshBusy;
  logic             internalClkEn, buffersOn, selfRefresh, casLatReserved;
  logic [ROW_W-1:0] refreshRow;
  logic [3:0]       writeEn, dqOutEn;
  logic [9:0]       h1, h2;                    // Expected, this and last
  logic [4:0]       pinsPrev;                  // Pins sent last cycle
  logic [3:0]       dqmPrev;                   // Mask sent last cycle
  logic [31:0]      seed           = 32'h7CF518E3;
  int               n_mismatch     = 0;
  int               total_checks   = 0;
  int               rowModel       = 0;        // Model of the row counter
  int               i, k, cl, gap;

  always #25 clock = ~clock;

  ctrl_model ctrl (.clock(clock), .rst_b(rst_b), .req(req),
    .reqCke(reqCke), .csB(csB), .rasB(rasB), .casB(casB), .weB(weB),
    .cke(cke));

  sdram_refresh_power_cmds dut (.clock(clock), .rst_b(rst_b), .csB(csB),
    .rasB(rasB), .casB(casB), .weB(weB), .cke(cke), .dqm(dqm),
    .allBanksIdle(allBanksIdle), .burstActive(burstActive),
    .burstRead(burstRead), .burstAutoPre(burstAutoPre),
    .readWordValid(readWordValid), .writeWordValid(writeWordValid),
    .casLatCode(casLatCode), .burstHalt(burstHalt), .readEnd(readEnd),
    .refreshPulse(refreshPulse), .refreshRow(refreshRow),
    .refreshBusy(refreshBusy), .internalClkEn(internalClkEn),
    .buffersOn(buffersOn), .selfRefresh(selfRefresh),
    .casLatReserved(casLatReserved), .writeEn(writeEn),
    .dqOutEn(dqOutEn));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare one result; unknowns never match
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // Advance edges, then settle 5 ns; all drives happen at this point
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Bounded wait for a refresh pulse; the count of edges comes back
  task automatic wait_pulse(input int bound, output int n);
    for (n = 0; n < bound && refreshPulse !== 1'b1; n++) step(1);
    if (n == bound) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // Burst of one refresh per row; the model spaces them by row cycle
  task automatic refresh_burst();
    int n;
    n = 0;
    req = 4'h1;
    repeat (3 * REFRESH_ROWS) begin
      step(1);
      if (refreshPulse === 1'b1) n++;
    end
    req = 4'h7;
    step(3);
    rowModel += n;
    check(16'(n), 16'(REFRESH_ROWS));
    check(refreshRow, 12'(rowModel));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    step(1);
    check({internalClkEn, buffersOn, selfRefresh, refreshBusy}, 4'hC);
    check(refreshRow, 12'h000);
    step(1);
    rst_b = 1'b1;
    step(1);
    // The first edge after release must not see enable low
    check({internalClkEn, buffersOn}, 2'h3);
    step(2);
    $display("test reset done");
    // Random pins; expectations are taken from the pins really driven,
    // since the controller model may replace a request by idle cycles.
    // Pins act one edge after capture, against the status of that cycle.
    // decode
    h1 = '0;
    h2 = '0;
    pinsPrev = 5'h0F;
    dqmPrev = dqm;
    for (i = 0; i < 300; i++) begin
      step(1);
      check({refreshPulse, burstHalt, writeEn, dqOutEn}, h1);
      if (h1[9]) rowModel++;
      check(refreshRow, 12'(rowModel));
      check(refreshBusy, h1[9] | h2[9]);
      h2 = h1;
      seed = xs(seed);
      req = (i >= 298) ? 4'h7 : seed[3:0];
      burstActive = seed[5];
      burstAutoPre = seed[6];
      dqm = seed[10:7];
      writeWordValid = seed[11];
      readWordValid = seed[12];
      casLatCode = seed[15:13];
      allBanksIdle = seed[16];
      #1;
      h1 = {pinsPrev == 5'h03,
            pinsPrev == 5'h0D && burstActive && !burstAutoPre,
            writeWordValid ? ~dqmPrev : 4'h0,
            readWordValid ? ~dqmPrev : 4'h0};
      pinsPrev = {csB, rasB, casB, weB, cke};
      dqmPrev = dqm;
      check(casLatReserved, casLatCode != CL2_CODE
                            && casLatCode != CL3_CODE);
    end
    {writeWordValid, readWordValid, burstActive, dqm} = 7'h00;
    allBanksIdle = 1'b1;
    step(3);
    $display("test random commands done");
    // Stopped read keeps data for the latency, then cuts the output
    for (i = 0; i < 2; i++) begin
      cl = 2 + i;
      casLatCode = i ? CL3_CODE : CL2_CODE;
      {burstActive, burstRead, burstAutoPre, readWordValid} = 4'hD;
      step(3);
      req = 4'h6;
      for (k = 1; k <= 6; k++) begin
        step(1);
        req = 4'h7;
        check(readEnd, k == 2 + cl);
        if (k >= 2) check(dqOutEn, (k >= 2 + cl) ? 4'h0 : 4'hF);
      end
      {burstActive, burstRead, readWordValid} = 3'h0;
      step(3);
    end
    $display("test burst stop done");
    // short suspend, far inside window
    // Clock enable low during a burst suspends, high resumes
    burstActive = 1'b1;
    reqCke = 1'b0;
    step(2);
    check({internalClkEn, buffersOn, selfRefresh}, 3'h2);
    reqCke = 1'b1;
    step(2);
    check(internalClkEn, 1'b1);
    burstActive = 1'b0;
    step(3);
    // Clock enable low with idle banks powers the buffers down
    reqCke = 1'b0;
    step(2);
    check({buffersOn, selfRefresh}, 2'h0);
    reqCke = 1'b1;
    step(2);
    check(buffersOn, 1'b1);
    step(3);
    $display("test suspend and power-down done");
    refresh_burst();
    // Self refresh: entry, internal rows and timing, exit
    req = 4'h1;
    reqCke = 1'b0;
    step(1);
    req = 4'h7;
    step(1);
    check({selfRefresh, buffersOn, internalClkEn}, 3'h4);
    wait_pulse(400, gap);
    rowModel++;
    check(refreshRow, 12'(rowModel));
    step(1);
    wait_pulse(400, gap);
    rowModel++;
    check(refreshRow, 12'(rowModel));
    check(16'(gap + 1), 16'(REFRESH_INTERVAL_CYC));
    reqCke = 1'b1;
    step(2);
    check({selfRefresh, buffersOn}, 2'h1);
    step(3);
    refresh_burst();
    $display("test self refresh done");
    tally_and_finish();
  end
endmodule
